// File: logic/scr_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the configuration block.
// Assumes: mclk at 100 MHz; APB byte addresses are four times the register index.
// Notes: Definitions only.
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

`define SCR_IDX_FRAME 2
`define SCR_IDX_STATUS 3
`define SCR_ADDR_FRAME 8'(4 * `SCR_IDX_FRAME)
`define SCR_ADDR_STATUS 8'(4 * `SCR_IDX_STATUS)

`define SCR_SEL_HI 15
`define SCR_SEL_LO 14
`define SCR_SEL_CFG 2'h2
`define SCR_RRS 13
`define SCR_RO 12
`define SCR_RLC 8
`define SCR_SSC_HI 7
`define SCR_SSC_LO 6
`define SCR_CMC 4
`define SCR_WEN 3
`define SCR_WSC 2
`define SCR_INHIBIT_OUTPUT_ENABLE 1
`define SCR_ILC 0
`define SCR_CFG_WMASK 16'h01df
`define SCR_CFG_RESET 16'h0100

`define SCR_ST_RST 0
`define SCR_ST_WLVL 1
`define SCR_ST_WEVT 2
`define SCR_ST_REJ 3
`define SCR_ST_SSC_LO 4
`define SCR_ST_SSC_HI 5

`define SCR_CLK_NS 10
`define SCR_T_RST_SHORT_NS 2000
`define SCR_T_RST_LONG_NS 20000
`define SCR_T_CYC_SHORT_NS 4000
`define SCR_T_CYC_LONG_NS 16000
`define SCR_T_CYC_ON_NS 500
`define SCR_RST_SHORT_CYC ((`SCR_T_RST_SHORT_NS + `SCR_CLK_NS - 1) / `SCR_CLK_NS)
`define SCR_RST_LONG_CYC ((`SCR_T_RST_LONG_NS + `SCR_CLK_NS - 1) / `SCR_CLK_NS)
`define SCR_CYC_SHORT_CYC ((`SCR_T_CYC_SHORT_NS + `SCR_CLK_NS - 1) / `SCR_CLK_NS)
`define SCR_CYC_LONG_CYC ((`SCR_T_CYC_LONG_NS + `SCR_CLK_NS - 1) / `SCR_CLK_NS)
`define SCR_CYC_ON_CYC ((`SCR_T_CYC_ON_NS + `SCR_CLK_NS - 1) / `SCR_CLK_NS)

`endif

// File: logic/scr_pkg.sv
// Purpose: Types shared by the configuration block.
// Assumes: Nothing beyond the constants header.
// Notes: Supply modes follow the two-bit control field order.
package scr_pkg;
   typedef enum logic [1:0] {SCR_SUP_OFF, SCR_SUP_ON, SCR_SUP_CYC1, SCR_SUP_CYC2} scr_supply_t;
endpackage

// File: logic/scr_reset_stretch.sv
// Purpose: Stretches any reset request to the selected lengthening time.
// Assumes: trigger is synchronous to mclk.
// Notes: Length is latched when the request ends; later changes of longSel do not shorten a running pulse.
`include "scr_regs.svh"
module scr_reset_stretch #(
   parameter int SHORT_CYC = `SCR_RST_SHORT_CYC,
   parameter int LONG_CYC = `SCR_RST_LONG_CYC
) (
   // Clock and reset
   input logic mclk,
   input logic srst,
   // Request
   input logic trigger,
   input logic longSel,
   // Reset line
   output logic resetOutN
);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   wire [15:0] lenSel = longSel ? 16'(LONG_CYC) : 16'(SHORT_CYC);

   // Reload while requested, so a short spike still yields the whole time
   assign cnt_next = trigger ? lenSel : (cnt_reg != 16'h0 ? cnt_reg - 16'h1 : 16'h0); // [R8]

   always_ff @(posedge mclk) begin
      if (srst) begin
         cnt_reg <= 16'(LONG_CYC);
         resetOutN <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         resetOutN <= (cnt_next == 16'h0);
      end
   end

   logic [15:0] lowRun;
   logic [15:0] lenSeen;
   always_ff @(posedge mclk) begin
      if (srst) begin
         lowRun <= 16'h0;
         lenSeen <= 16'(LONG_CYC);
      end else if (trigger) begin
         lowRun <= 16'h0;
         lenSeen <= lenSel;
      end else if (!resetOutN) begin
         lowRun <= lowRun + 16'h1;
      end
   end

   chk_stretch_length: assert property (@(posedge mclk) disable iff (srst) // [R8]
      $rose(resetOutN) |-> lowRun == lenSeen)
      else $error("reset pulse length differs from selected time");
   chk_stretch_start: assert property (@(posedge mclk) disable iff (srst) // [R8]
      trigger |=> !resetOutN)
      else $error("reset request did not pull the line low");
endmodule

// File: logic/scr_config.sv
// Purpose: System configuration register with frame decode, readback and the logic it steers.
// Assumes: Mode inputs are synchronous one-cycle or level signals from the mode controller.
// Notes: Frames arrive as APB writes; replies are read back from the same word.
// Overview of operation
// R1 - Frames with top bits 10 address this register; others are ignored.
// R2 - Readback select one returns general feedback zero, else configuration contents.
// R3 - Read-only flag set keeps the register; clear stores the frame's fields.
// R4 - Host writes zero to reserved bits 11, 10 and 5.
// R5 - Host writes zero to reserved bit 9.
// R6 - Reset length select picks long time when one, short when zero.
// R7 - Restart or fail-safe entry sets reset length select automatically.
// R8 - External short reset pulses are stretched to the programmed time.
// R9 - Supply field: 11 long cyclic, 10 short cyclic, 01 on, 00 off.
// R10 - Monitor bit set: standby current rise resets if watchdog was off.
// R11 - Monitor bit clear: current rise reactivates watchdog and forces enabled interrupt.
// R12 - Wake sample bit selects cyclic sampling when one, continuous when zero.
// R13 - Inhibit enable drives the inhibit output when one, floats it when zero.
// R14 - Inhibit level bit drives output high when one, low when zero.
// R15 - Wake disabled: wake input ignored and wake status bits frozen; a status write still clears the event bit.
// R16 - Configuration readback shows held values including automatic reset length setting.
//
// The APB slave port was left to the implementer.
`include "scr_regs.svh"
module scr_config #(
   parameter int RST_SHORT_CYC = `SCR_RST_SHORT_CYC,
   parameter int RST_LONG_CYC = `SCR_RST_LONG_CYC,
   parameter int CYC_SHORT_CYC = `SCR_CYC_SHORT_CYC,
   parameter int CYC_LONG_CYC = `SCR_CYC_LONG_CYC,
   parameter int CYC_ON_CYC = `SCR_CYC_ON_CYC
) (
   // Clock and reset
   input logic mclk,
   input logic srst,
   // APB slave
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Mode controller
   input logic restartEntry,
   input logic failSafeEntry,
   input logic standbyMode,
   input logic watchdogOffInStandby,
   input logic currentRise,
   input logic currentIrqEnable,
   input logic [15:0] gpFeedback0,
   // Pins
   input logic extResetInN,
   input logic wakePin,
   output logic resetOutN,
   output logic switchedSupplyOn,
   output logic inhibitOut,
   output logic inhibitOeN,
   // Status and events
   output logic wakeEventStatus,
   output logic wakeLevelStatus,
   output logic watchdogReactivate,
   output logic irqForce,
   output scr_pkg::scr_supply_t supplyMode
);
   import scr_pkg::*;

   logic [15:0] cfg_reg;
   logic [15:0] cfg_next;
   logic rrs_reg;
   logic reject_reg;
   logic resetReq_reg;
   logic riseSeen_reg;
   logic [15:0] cyc_reg;
   scr_supply_t supplyDec;

   // Bus decode
   wire setup = psel & ~penable;
   wire access = psel & penable & pready;
   wire hitFrame = (paddr == `SCR_ADDR_FRAME);
   wire hitStatus = (paddr == `SCR_ADDR_STATUS);
   wire mapped = hitFrame | hitStatus;
   wire frameWr = access & pwrite & hitFrame;
   wire statusWr = access & pwrite & hitStatus;
   wire [15:0] frame = pwdata[15:0];

   // Frame handling
   wire selOk = (frame[`SCR_SEL_HI:`SCR_SEL_LO] == `SCR_SEL_CFG); // [R1]
   wire frameTaken = frameWr & selOk; // [R1]
   wire cfgStore = frameTaken & ~frame[`SCR_RO]; // [R3]
   wire autoLong = restartEntry | failSafeEntry;

   // Reserved bits are masked off, so a stray one from the host has no effect
   always_comb begin
      cfg_next = cfg_reg;
      if (cfgStore) begin
         cfg_next = frame & `SCR_CFG_WMASK; // [R3]
      end
      if (autoLong) begin
         cfg_next[`SCR_RLC] = 1'b1; // [R7]
      end
   end

   // Readback is taken from cfg_reg, so an automatic reset length change is visible from the cycle after entry
   wire [15:0] readback = rrs_reg ? gpFeedback0 : cfg_reg; // [R2] [R16]
   wire clrWake = statusWr & pwdata[`SCR_ST_WEVT];

   logic [31:0] statusWord;
   always_comb begin
      statusWord = 32'h0;
      statusWord[`SCR_ST_RST] = ~resetOutN;
      statusWord[`SCR_ST_WLVL] = wakeLevelStatus;
      statusWord[`SCR_ST_WEVT] = wakeEventStatus;
      statusWord[`SCR_ST_REJ] = reject_reg;
      statusWord[`SCR_ST_SSC_HI:`SCR_ST_SSC_LO] = cfg_reg[`SCR_SSC_HI:`SCR_SSC_LO];
   end

   wire [31:0] rdNext = hitFrame ? {16'h0, readback} : (hitStatus ? statusWord : 32'h0);

   // Zero wait states: ready rises for the access phase only
   always_ff @(posedge mclk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= (setup & ~pwrite) ? rdNext : 32'h0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         cfg_reg <= `SCR_CFG_RESET;
         rrs_reg <= 1'b0;
         reject_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         if (frameTaken) begin
            rrs_reg <= frame[`SCR_RRS]; // [R2]
         end
         if (frameWr) begin
            reject_reg <= ~selOk;
         end
      end
   end

   // Switched supply decode
   always_comb begin
      case (cfg_reg[`SCR_SSC_HI:`SCR_SSC_LO]) // [R9]
         2'h3: supplyDec = SCR_SUP_CYC2;
         2'h2: supplyDec = SCR_SUP_CYC1;
         2'h1: supplyDec = SCR_SUP_ON;
         default: supplyDec = SCR_SUP_OFF;
      endcase
   end

   // Cycle divider; its on-window end doubles as the cyclic wake sample enable
   wire [15:0] period = (supplyDec == SCR_SUP_CYC2) ? 16'(CYC_LONG_CYC) : 16'(CYC_SHORT_CYC);
   wire cycWrap = (cyc_reg >= period - 16'h1);
   wire onWin = (cyc_reg < 16'(CYC_ON_CYC));
   wire sampleTick = (cyc_reg == 16'(CYC_ON_CYC - 1));
   wire supplyCyclic = (supplyDec == SCR_SUP_CYC1) || (supplyDec == SCR_SUP_CYC2);

   logic supplyOnNext;
   always_comb begin
      case (supplyDec) // [R9]
         SCR_SUP_ON: supplyOnNext = 1'b1;
         SCR_SUP_CYC1: supplyOnNext = onWin;
         SCR_SUP_CYC2: supplyOnNext = onWin;
         default: supplyOnNext = 1'b0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         cyc_reg <= 16'h0;
         switchedSupplyOn <= 1'b0;
         supplyMode <= SCR_SUP_OFF;
      end else begin
         cyc_reg <= cycWrap ? 16'h0 : cyc_reg + 16'h1;
         switchedSupplyOn <= supplyOnNext;
         supplyMode <= supplyDec;
      end
   end

   // Wake input
   wire wakeEn = cfg_reg[`SCR_WEN];
   wire sampleEn = wakeEn & (~cfg_reg[`SCR_WSC] | sampleTick); // [R12] [R15]
   wire wakeChange = sampleEn & (wakePin != wakeLevelStatus);

   always_ff @(posedge mclk) begin
      if (srst) begin
         wakeLevelStatus <= 1'b0;
         wakeEventStatus <= 1'b0;
      end else begin
         if (sampleEn) begin
            wakeLevelStatus <= wakePin; // [R15]
         end
         // A change in the clearing cycle keeps the flag set
         wakeEventStatus <= wakeChange | (wakeEventStatus & ~clrWake);
      end
   end

   // Inhibit output; level held low while floating so the pad sees a defined value
   always_ff @(posedge mclk) begin
      if (srst) begin
         inhibitOut <= 1'b0;
         inhibitOeN <= 1'b1;
      end else begin
         inhibitOeN <= ~cfg_reg[`SCR_INHIBIT_OUTPUT_ENABLE]; // [R13]
         inhibitOut <= cfg_reg[`SCR_INHIBIT_OUTPUT_ENABLE] & cfg_reg[`SCR_ILC]; // [R14]
      end
   end

   // Current monitor: act once per rise, on its leading edge
   wire riseStb = standbyMode & currentRise & ~riseSeen_reg;
   wire cmcSet = cfg_reg[`SCR_CMC];

   always_ff @(posedge mclk) begin
      if (srst) begin
         riseSeen_reg <= 1'b0;
         resetReq_reg <= 1'b0;
         watchdogReactivate <= 1'b0;
         irqForce <= 1'b0;
      end else begin
         riseSeen_reg <= standbyMode & currentRise;
         resetReq_reg <= riseStb & cmcSet & watchdogOffInStandby; // [R10]
         watchdogReactivate <= riseStb & ~cmcSet; // [R11]
         irqForce <= riseStb & ~cmcSet & currentIrqEnable; // [R11]
      end
   end

   scr_reset_stretch #(
      .SHORT_CYC(RST_SHORT_CYC),
      .LONG_CYC(RST_LONG_CYC)
   ) u_stretch (
      .mclk(mclk),
      .srst(srst),
      .trigger(~extResetInN | resetReq_reg), // [R8]
      .longSel(cfg_reg[`SCR_RLC]), // [R6]
      .resetOutN(resetOutN)
   );

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   sequence seqCmcRise;
      riseStb && cmcSet && watchdogOffInStandby;
   endsequence
   sequence seqResetDriven;
      resetReq_reg ##1 !resetOutN;
   endsequence
   sequence seqWakeDiffers;
      wakeEn && !cfg_reg[`SCR_WSC] && (wakePin != wakeLevelStatus);
   endsequence
   sequence seqPulseOnce;
      watchdogReactivate ##1 !watchdogReactivate;
   endsequence

   chk_frame_select_miss: assert property ( // [R1]
      frameWr && !selOk && !autoLong |=> $stable(cfg_reg) && $stable(rrs_reg))
      else $error("frame with wrong select changed the register");
   chk_readback_gp: assert property ( // [R2]
      setup && !pwrite && hitFrame && rrs_reg |=> prdata[15:0] == $past(gpFeedback0))
      else $error("readback select did not return general feedback");
   chk_readonly_hold: assert property ( // [R3]
      frameTaken && frame[`SCR_RO] && !autoLong |=> $stable(cfg_reg))
      else $error("read-only frame altered the register");
   chk_write_store: assert property ( // [R3]
      cfgStore && !autoLong |=> cfg_reg == ($past(frame) & `SCR_CFG_WMASK))
      else $error("write frame not stored");
   chk_auto_long: assert property ( // [R7] [R16]
      autoLong |=> cfg_reg[`SCR_RLC] && (rrs_reg || readback[`SCR_RLC]))
      else $error("reset length select not set on mode entry");
   chk_supply_on: assert property ( // [R9]
      supplyDec == SCR_SUP_ON ##1 supplyDec == SCR_SUP_ON |-> switchedSupplyOn && supplyMode == SCR_SUP_ON)
      else $error("supply not on in continuous mode");
   chk_supply_off: assert property ( // [R9]
      supplyDec == SCR_SUP_OFF ##1 supplyDec == SCR_SUP_OFF |-> !switchedSupplyOn)
      else $error("supply on while switched off");
   chk_cmc_reset: assert property ( // [R10]
      seqCmcRise |=> seqResetDriven)
      else $error("current rise did not cause a reset");
   chk_cmc_irq: assert property ( // [R11]
      riseStb && !cmcSet && currentIrqEnable |=> irqForce && watchdogReactivate && !resetReq_reg)
      else $error("current rise did not reactivate and interrupt");
   chk_wake_cyclic: assert property ( // [R12]
      wakeEn && cfg_reg[`SCR_WSC] && !sampleTick |=> $stable(wakeLevelStatus))
      else $error("wake sampled outside the cyclic window");
   chk_inhibit_drive: assert property ( // [R13]
      ##1 1'b1 |-> inhibitOeN == !$past(cfg_reg[`SCR_INHIBIT_OUTPUT_ENABLE]) &&
         inhibitOut == ($past(cfg_reg[`SCR_INHIBIT_OUTPUT_ENABLE]) && $past(cfg_reg[`SCR_ILC])))
      else $error("inhibit output disagrees with its enable and level");
   chk_wake_frozen: assert property ( // [R15]
      !wakeEn && !clrWake |=> $stable(wakeLevelStatus) && $stable(wakeEventStatus))
      else $error("wake status changed while wake is disabled");
   chk_readback_cfg: assert property ( // [R16]
      setup && !pwrite && hitFrame && !rrs_reg |=> prdata[15:0] == $past(cfg_reg))
      else $error("configuration readback differs from held value");

   // Bus timing
   chk_ready_timing: assert property (
      1'b1 |=> pready == $past(setup))
      else $error("ready not exactly one cycle after setup");
   chk_err_unmapped: assert property (
      setup && !mapped |=> pready && pslverr)
      else $error("unmapped access not flagged");

   // Frame decode
   chk_select_update: assert property ( // [R2]
      frameTaken |=> rrs_reg == $past(frame[`SCR_RRS]))
      else $error("readback select not taken from frame");
   chk_reject_flag: assert property ( // [R1]
      frameWr |=> reject_reg == !$past(selOk))
      else $error("reject flag disagrees with frame select");

   // Supply, wake, inhibit and monitor outputs
   chk_supply_mode: assert property ( // [R9]
      1'b1 |=> supplyMode == $past(supplyDec))
      else $error("supply mode output lags its field");
   chk_supply_cyclic: assert property ( // [R9]
      supplyCyclic |=> switchedSupplyOn == $past(onWin))
      else $error("cyclic supply outside its on window");
   chk_cyclic_period: assert property ( // [R9]
      supplyCyclic && $stable(period) |-> cyc_reg < period)
      else $error("cycle counter beyond its period");
   chk_wake_continuous: assert property ( // [R12]
      seqWakeDiffers |=> wakeLevelStatus == $past(wakePin) && wakeEventStatus)
      else $error("continuous wake sampling missed a change");
   chk_wake_set_wins: assert property ( // [R12]
      wakeChange |=> wakeEventStatus)
      else $error("wake event lost against a clear");
   chk_wake_clear: assert property (
      clrWake && !wakeChange |=> !wakeEventStatus)
      else $error("wake event not cleared by software");
   chk_inhibit_level: assert property ( // [R14]
      cfg_reg[`SCR_INHIBIT_OUTPUT_ENABLE] |=> inhibitOut == $past(cfg_reg[`SCR_ILC]))
      else $error("inhibit level differs from its control bit");
   chk_irq_gated: assert property ( // [R11]
      riseStb && !cmcSet && !currentIrqEnable |=> watchdogReactivate && !irqForce)
      else $error("interrupt forced while disabled");
   chk_cmc_quiet: assert property ( // [R10]
      riseStb && cmcSet |=> !watchdogReactivate && !irqForce)
      else $error("monitor reset mode also reactivated the watchdog");
   chk_pulse_single: assert property ( // [R11]
      watchdogReactivate |-> seqPulseOnce)
      else $error("watchdog reactivation longer than one cycle");
   chk_irq_single: assert property ( // [R11]
      irqForce |=> !irqForce)
      else $error("forced interrupt longer than one cycle");
endmodule

// File: bench/scr_host_model.sv
// Purpose: Host side that issues configuration frames as APB transfers.
// Assumes: One transfer at a time; pready is sampled at rising edges.
// Notes: Reserved frame bits always go out as zero, so no future function can be triggered by accident.
`include "scr_regs.svh"
module scr_host_model (
   // Clock
   input logic mclk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // Holds the request until pready is seen at a rising edge
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic frame(input logic readback_select, input logic ro, input logic [11:0] f);
      logic [31:0] d;
      logic e;
      xfer(1'b1, `SCR_ADDR_FRAME, {16'h0, 2'b10, readback_select, ro, f & 12'h1df}, d, e);
   endtask
endmodule

// File: bench/scr_config_tb.sv
// Purpose: Self-checking bench for the system configuration block.
// Assumes: Short timing parameters; the host model issues all APB traffic.
// Notes: Pulse and reset counters sample on falling edges to stay clear of update races.
`include "scr_regs.svh"
`define CHK(nm, ex, gt) begin cmpCount++; if ((gt) !== (ex)) begin errTotal++; $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module scr_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import scr_pkg::*;
   localparam int SH = 4;
   localparam int LG = 8;
   logic mclk, srst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic restartEntry, failSafeEntry, standbyMode, watchdogOffInStandby, currentRise, currentIrqEnable;
   logic [15:0] gpFeedback0;
   logic extResetInN, wakePin, resetOutN, switchedSupplyOn, inhibitOut, inhibitOeN;
   logic wakeEventStatus, wakeLevelStatus, watchdogReactivate, irqForce;
   scr_supply_t supplyMode;
   int errTotal, cmpCount, lowCnt, wdCnt, irqCnt, onCnt;

   scr_config #(.RST_SHORT_CYC(SH), .RST_LONG_CYC(LG), .CYC_SHORT_CYC(8), .CYC_LONG_CYC(16), .CYC_ON_CYC(2))
   scr_config_i (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .restartEntry(restartEntry),
      .failSafeEntry(failSafeEntry), .standbyMode(standbyMode), .watchdogOffInStandby(watchdogOffInStandby),
      .currentRise(currentRise), .currentIrqEnable(currentIrqEnable), .gpFeedback0(gpFeedback0),
      .extResetInN(extResetInN), .wakePin(wakePin), .resetOutN(resetOutN), .switchedSupplyOn(switchedSupplyOn),
      .inhibitOut(inhibitOut), .inhibitOeN(inhibitOeN), .wakeEventStatus(wakeEventStatus),
      .wakeLevelStatus(wakeLevelStatus), .watchdogReactivate(watchdogReactivate), .irqForce(irqForce),
      .supplyMode(supplyMode));

   scr_host_model scr_host_model_i (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(negedge mclk) begin
      lowCnt += (resetOutN === 1'b0);
      wdCnt += (watchdogReactivate === 1'b1);
      irqCnt += (irqForce === 1'b1);
      onCnt += (switchedSupplyOn === 1'b1);
   end

   task automatic rdReg(input logic [7:0] a);
      scr_host_model_i.xfer(1'b0, a, 32'h0, rd, err);
   endtask

   // Outputs follow the register one edge later, so settle before returning
   task automatic cfg(input logic readback_select, input logic ro, input logic [11:0] f);
      scr_host_model_i.frame(readback_select, ro, f);
      repeat (2) @(posedge mclk);
   endtask

   task automatic clr();
      lowCnt = 0;
      wdCnt = 0;
      irqCnt = 0;
      onCnt = 0;
   endtask

   task automatic extPulse();
      clr();
      @(posedge mclk);
      extResetInN <= 1'b0;
      @(posedge mclk);
      extResetInN <= 1'b1;
      repeat (30) @(posedge mclk);
   endtask

   task automatic completeRun();
      $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
      if (errTotal == 0 && cmpCount > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge mclk);
      errTotal++;
      completeRun();
   end

   initial begin
      srst = 1'b1;
      {restartEntry, failSafeEntry, standbyMode, watchdogOffInStandby, currentRise, currentIrqEnable} = 6'h00;
      gpFeedback0 = 16'h5a3c;
      extResetInN = 1'b1;
      wakePin = 1'b0;
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      repeat (LG + 4) @(posedge mclk);
      `CHK("reset line", 1'b1, resetOutN)
      `CHK("inh float", 1'b1, inhibitOeN)
      rdReg(`SCR_ADDR_FRAME);
      `CHK("cfg reset", 32'h0000_0100, rd)
      cfg(1'b0, 1'b0, 12'h0cb);
      rdReg(`SCR_ADDR_FRAME);
      `CHK("cfg store", 32'h0000_00cb, rd)
      cfg(1'b0, 1'b1, 12'h000);
      rdReg(`SCR_ADDR_FRAME);
      `CHK("ro keep", 32'h0000_00cb, rd)
      scr_host_model_i.xfer(1'b1, `SCR_ADDR_FRAME, 32'h0000_4000, rd, err);
      rdReg(`SCR_ADDR_FRAME);
      `CHK("bad select", 32'h0000_00cb, rd)
      rdReg(`SCR_ADDR_STATUS);
      `CHK("reject flag", 1'b1, rd[`SCR_ST_REJ])
      cfg(1'b1, 1'b1, 12'h000);
      rdReg(`SCR_ADDR_FRAME);
      `CHK("gp feedback", 32'h0000_5a3c, rd)
      for (int m = 0; m < 4; m++) begin
         cfg(1'b0, 1'b0, 12'(m * 64 + m));
         `CHK("supply mode", 2'(m), supplyMode)
         `CHK("inh enable", 1'(~m[1]), inhibitOeN)
         `CHK("inh level", 1'(m[1] & m[0]), inhibitOut)
         if (m < 2)
            `CHK("supply on", 1'(m), switchedSupplyOn)
      end
      // Four short or two long periods, each on for two cycles
      for (int c = 2; c < 4; c++) begin
         cfg(1'b0, 1'b0, 12'(c * 64));
         clr();
         repeat (32) @(posedge mclk);
         `CHK("cyclic on time", (c == 2) ? 8 : 4, onCnt)
      end
      extPulse();
      `CHK("short stretch", SH, lowCnt)
      cfg(1'b0, 1'b0, 12'h100);
      extPulse();
      `CHK("long stretch", LG, lowCnt)
      for (int k = 0; k < 2; k++) begin
         cfg(1'b0, 1'b0, 12'h000);
         if (k == 0)
            restartEntry <= 1'b1;
         else
            failSafeEntry <= 1'b1;
         @(posedge mclk);
         restartEntry <= 1'b0;
         failSafeEntry <= 1'b0;
         rdReg(`SCR_ADDR_FRAME);
         `CHK("auto long", 32'h0000_0100, rd)
      end
      extPulse();
      `CHK("forced long", LG, lowCnt)
      cfg(1'b0, 1'b0, 12'h000);
      clr();
      standbyMode <= 1'b1;
      currentIrqEnable <= 1'b1;
      currentRise <= 1'b1;
      repeat (30) @(posedge mclk);
      `CHK("wd reactivate", 1, wdCnt)
      `CHK("irq force", 1, irqCnt)
      `CHK("no reset", 0, lowCnt)
      currentRise <= 1'b0;
      currentIrqEnable <= 1'b0;
      repeat (2) @(posedge mclk);
      clr();
      currentRise <= 1'b1;
      repeat (4) @(posedge mclk);
      `CHK("wd no irq", 1, wdCnt)
      `CHK("irq gated", 0, irqCnt)
      currentRise <= 1'b0;
      cfg(1'b0, 1'b0, 12'h010);
      clr();
      watchdogOffInStandby <= 1'b1;
      currentRise <= 1'b1;
      repeat (30) @(posedge mclk);
      `CHK("monitor reset", SH, lowCnt)
      `CHK("no reactivate", 0, wdCnt)
      currentRise <= 1'b0;
      standbyMode <= 1'b0;
      cfg(1'b0, 1'b0, 12'h000);
      wakePin <= 1'b1;
      repeat (4) @(posedge mclk);
      rdReg(`SCR_ADDR_STATUS);
      `CHK("wake frozen", 2'b00, rd[2:1])
      cfg(1'b0, 1'b0, 12'h008);
      rdReg(`SCR_ADDR_STATUS);
      `CHK("wake seen", 2'b11, rd[2:1])
      `CHK("wake level pin", 1'b1, wakeLevelStatus)
      scr_host_model_i.xfer(1'b1, `SCR_ADDR_STATUS, 32'h4, rd, err);
      cfg(1'b0, 1'b0, 12'h00c);
      wakePin <= 1'b0;
      repeat (40) @(posedge mclk);
      rdReg(`SCR_ADDR_STATUS);
      `CHK("wake cyclic", 2'b10, rd[2:1])
      `CHK("wake event pin", 1'b1, wakeEventStatus)
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      `CHK("reset again", 1'b0, resetOutN)
      rdReg(`SCR_ADDR_FRAME);
      `CHK("cfg reset again", 32'h0000_0100, rd)
      scr_host_model_i.xfer(1'b0, 8'h10, 32'h0, rd, err);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h0, rd)
      completeRun();
   end
endmodule
